// [rtl/hwps_pkg.sv]
package hwps_pkg;

    // register byte offsets
    localparam logic [7:0] HWPS_OFS_CTRL     = 8'h00;
    localparam logic [7:0] HWPS_OFS_STAT     = 8'h04;
    localparam logic [7:0] HWPS_OFS_SAMPLE   = 8'h08;
    localparam logic [7:0] HWPS_OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] HWPS_OFS_IRQ_MASK = 8'h10;

    // control field positions
    localparam int HWPS_CTRL_STANDBY_BIT = 0;
    localparam int HWPS_CTRL_FORCE_BIT   = 1;
    localparam int HWPS_CTRL_TO_LSB      = 2;

    // status field positions
    localparam int HWPS_STAT_FULL_BIT  = 0;
    localparam int HWPS_STAT_EMPTY_BIT = 1;
    localparam int HWPS_STAT_STATE_LSB = 2;
    localparam int HWPS_STAT_PWR_BIT   = 5;

    // interrupt bit positions
    localparam int HWPS_IRQ_WAKE_BIT    = 0;
    localparam int HWPS_IRQ_DRAIN_BIT   = 1;
    localparam int HWPS_IRQ_IDLE_BIT    = 2;
    localparam int HWPS_IRQ_REFUSE_BIT  = 3;
    localparam int HWPS_IRQ_W           = 4;

    // reset values
    localparam logic [1:0] HWPS_RST_TO_SEL = 2'h0;
    localparam logic [3:0] HWPS_RST_MASK   = 4'h0;
    localparam logic [7:0] HWPS_MID_SCALE  = 8'h00;

    // axi responses
    localparam logic [1:0] HWPS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] HWPS_RESP_SLVERR = 2'h2;

    // sample queue
    localparam int HWPS_QDEPTH = 100;
    localparam int HWPS_PTR_W  = 7;

    // timing
    localparam int HWPS_CLK_HZ        = 50_000_000;
    localparam int HWPS_CLK_PERIOD_NS = 20;
    localparam int HWPS_WAKE_TIME_NS  = 2_000_000;
    localparam int HWPS_TO_STEP_NS    = 5_000_000;
    localparam int HWPS_SAMPLE_HZ     = 8_000;
    localparam int HWPS_WAKE_CYC  = (HWPS_WAKE_TIME_NS + HWPS_CLK_PERIOD_NS - 1)
                                    / HWPS_CLK_PERIOD_NS;
    localparam int HWPS_TO_STEP_CYC = (HWPS_TO_STEP_NS + HWPS_CLK_PERIOD_NS - 1)
                                      / HWPS_CLK_PERIOD_NS;
    localparam int HWPS_TICK_CYC  = HWPS_CLK_HZ / HWPS_SAMPLE_HZ;
    localparam int HWPS_CNT_W     = 21;

    typedef enum logic [2:0] {
        HWPS_ST_STANDBY,
        HWPS_ST_IDLE,
        HWPS_ST_WAKE,
        HWPS_ST_PLAY,
        HWPS_ST_LINGER
    } hwps_state_t;

    typedef struct packed {
        logic [1:0] to_sel;
        logic       force_on;
        logic       standby;
    } hwps_ctrl_t;

    typedef struct packed {
        logic [7:0] data;
        logic       strobe;
    } hwps_dac_t;

endpackage

// [rtl/hwps_sequencer.sv]
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module hwps_sequencer
    import hwps_pkg::*;
#(
    parameter int unsigned WAKE_CYC    = HWPS_WAKE_CYC,
    parameter int unsigned TICK_CYC    = HWPS_TICK_CYC,
    parameter int unsigned TO_STEP_CYC = HWPS_TO_STEP_CYC
)(
    input  wire logic        core_clk,      // 50 MHz clock
    input  wire logic        sys_rst,       // async reset, high
    input  wire logic [7:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [7:0]  s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready,  // read data ready
    output logic             boost_en,      // boost converter enable
    output logic             amp_en,        // amplifier enable
    output hwps_dac_t        dac,           // sample to dac with strobe
    output logic             irq            // level interrupt
);

    hwps_state_t             state_r;
    hwps_ctrl_t              ctrl_r;
    logic                    standby_prev_r;
    logic [HWPS_IRQ_W-1:0]   irq_stat_r;
    logic [HWPS_IRQ_W-1:0]   irq_mask_r;
    logic                    sample_queue_full_flag;
    logic [HWPS_CNT_W-1:0]   tmr_r;
    logic [HWPS_CNT_W-1:0]   tick_r;
    logic                    pwr_r;
    hwps_dac_t               dac_r;

    logic [7:0]              qmem [0:HWPS_QDEPTH-1];
    logic [HWPS_PTR_W-1:0]   wr_ptr_r;
    logic [HWPS_PTR_W-1:0]   rd_ptr_r;
    logic [HWPS_PTR_W-1:0]   qcount_r;

    logic                    aw_held_r;
    logic                    w_held_r;
    logic [7:0]              awaddr_r;
    logic [31:0]             wdata_r;
    logic [3:0]              wstrb_r;
    logic                    bvalid_r;
    logic [1:0]              bresp_r;
    logic                    rvalid_r;
    logic [31:0]             rdata_r;
    logic [1:0]              rresp_r;

    logic                    q_empty;
    logic                    q_full;
    logic                    do_write;
    logic                    do_read;
    logic                    wr_sample;
    logic                    push;
    logic                    pop;
    logic                    standby_rise;
    logic                    standby_fall;
    logic [HWPS_IRQ_W-1:0]   irq_ev;
    logic [HWPS_CNT_W-1:0]   linger_load;

    assign q_empty      = (qcount_r == HWPS_PTR_W'(0));
    assign q_full       = (qcount_r == HWPS_PTR_W'(HWPS_QDEPTH));
    assign do_write     = aw_held_r && w_held_r && !bvalid_r;
    assign do_read      = s_axi_arvalid && s_axi_arready;
    assign wr_sample    = do_write && (awaddr_r == HWPS_OFS_SAMPLE) && wstrb_r[0];
    assign push         = wr_sample && !q_full && (state_r != HWPS_ST_STANDBY);
    assign pop          = (state_r == HWPS_ST_PLAY) && (tick_r == '0) && !q_empty;
    assign standby_rise = ctrl_r.standby && !standby_prev_r;
    assign standby_fall = !ctrl_r.standby && standby_prev_r;
    assign linger_load  = HWPS_CNT_W'(TO_STEP_CYC * (32'(ctrl_r.to_sel) + 32'd1) - 32'd1);

    // ---------------- axi4-lite slave ----------------
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= HWPS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                unique case (awaddr_r)
                    HWPS_OFS_CTRL, HWPS_OFS_IRQ_STAT, HWPS_OFS_IRQ_MASK:
                        bresp_r <= HWPS_RESP_OKAY;
                    // slverr plays the part of a nak so the host resends this byte
                    HWPS_OFS_SAMPLE:
                        bresp_r <= push ? HWPS_RESP_OKAY : HWPS_RESP_SLVERR;
                    default:
                        bresp_r <= HWPS_RESP_SLVERR;
                endcase
            end
            else if (bvalid_r && s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= HWPS_RESP_OKAY;
        end
        else if (do_read)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= HWPS_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
            unique case (s_axi_araddr)
                HWPS_OFS_CTRL:     rdata_r <= 32'(ctrl_r);
                HWPS_OFS_STAT:
                begin
                    rdata_r[HWPS_STAT_FULL_BIT]  <= sample_queue_full_flag;
                    rdata_r[HWPS_STAT_EMPTY_BIT] <= q_empty;
                    rdata_r[HWPS_STAT_STATE_LSB +: 3] <= state_r;
                    rdata_r[HWPS_STAT_PWR_BIT]   <= pwr_r;
                end
                HWPS_OFS_SAMPLE:   rdata_r <= 32'h0000_0000;
                HWPS_OFS_IRQ_STAT: rdata_r <= 32'(irq_stat_r);
                HWPS_OFS_IRQ_MASK: rdata_r <= 32'(irq_mask_r);
                default:           rresp_r <= HWPS_RESP_SLVERR;
            endcase
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // ---------------- software registers ----------------
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_r         <= '{to_sel: HWPS_RST_TO_SEL, force_on: 1'b0, standby: 1'b1};
            standby_prev_r <= 1'b1;
            irq_mask_r     <= HWPS_RST_MASK;
        end
        else
        begin
            standby_prev_r <= ctrl_r.standby;
            if (do_write && wstrb_r[0] && (awaddr_r == HWPS_OFS_CTRL))
            begin
                ctrl_r.standby  <= wdata_r[HWPS_CTRL_STANDBY_BIT];
                ctrl_r.force_on <= wdata_r[HWPS_CTRL_FORCE_BIT];
                ctrl_r.to_sel   <= wdata_r[HWPS_CTRL_TO_LSB +: 2];
            end
            if (do_write && wstrb_r[0] && (awaddr_r == HWPS_OFS_IRQ_MASK))
            begin
                irq_mask_r <= wdata_r[HWPS_IRQ_W-1:0];
            end
        end
    end

    // interrupt events; a new event wins over a write-one clear
    always_comb
    begin
        irq_ev = '0;
        irq_ev[HWPS_IRQ_WAKE_BIT]   = (state_r == HWPS_ST_WAKE) && (tmr_r == '0);
        irq_ev[HWPS_IRQ_DRAIN_BIT]  = (state_r == HWPS_ST_PLAY) && (tick_r == '0) && q_empty
                                      && !ctrl_r.force_on;
        irq_ev[HWPS_IRQ_IDLE_BIT]   = (state_r == HWPS_ST_LINGER) && (tmr_r == '0) && q_empty
                                      && !ctrl_r.force_on;
        irq_ev[HWPS_IRQ_REFUSE_BIT] = wr_sample && !push;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_stat_r <= '0;
        end
        else
        begin
            if (do_write && wstrb_r[0] && (awaddr_r == HWPS_OFS_IRQ_STAT))
            begin
                irq_stat_r <= (irq_stat_r & ~wdata_r[HWPS_IRQ_W-1:0]) | irq_ev;
            end
            else
            begin
                irq_stat_r <= irq_stat_r | irq_ev;
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // full flag is sticky; a status read clears it unless the queue is still full
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sample_queue_full_flag <= 1'b0;
        end
        else if (q_full)
        begin
            sample_queue_full_flag <= 1'b1;
        end
        else if (do_read && (s_axi_araddr == HWPS_OFS_STAT))
        begin
            sample_queue_full_flag <= 1'b0;
        end
    end

    // ---------------- sample queue ----------------
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            qmem[wr_ptr_r] <= wdata_r[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            qcount_r <= '0;
        end
        else if (standby_rise)
        begin
            // pending samples are dropped on entering standby
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            qcount_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == HWPS_PTR_W'(HWPS_QDEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == HWPS_PTR_W'(HWPS_QDEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                qcount_r <= qcount_r + 1'b1;
            end
            else if (pop && !push)
            begin
                qcount_r <= qcount_r - 1'b1;
            end
        end
    end

    // ---------------- power sequencer ----------------
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= HWPS_ST_STANDBY;
            tmr_r   <= '0;
        end
        else if (standby_rise)
        begin
            state_r <= HWPS_ST_STANDBY;
        end
        else
        begin
            unique case (state_r)
                HWPS_ST_STANDBY:
                    if (standby_fall)
                    begin
                        state_r <= HWPS_ST_IDLE;
                    end
                HWPS_ST_IDLE:
                    if (ctrl_r.force_on || !q_empty)
                    begin
                        state_r <= HWPS_ST_WAKE;
                        tmr_r   <= HWPS_CNT_W'(WAKE_CYC - 1);
                    end
                HWPS_ST_WAKE:
                    // later pushes leave the running count alone
                    if (tmr_r == '0)
                    begin
                        state_r <= HWPS_ST_PLAY;
                    end
                    else
                    begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                HWPS_ST_PLAY:
                    if (tick_r == '0 && q_empty && !ctrl_r.force_on)
                    begin
                        state_r <= HWPS_ST_LINGER;
                        tmr_r   <= linger_load;
                    end
                HWPS_ST_LINGER:
                    if (!q_empty || ctrl_r.force_on)
                    begin
                        state_r <= HWPS_ST_PLAY;
                    end
                    else if (tmr_r == '0)
                    begin
                        state_r <= HWPS_ST_IDLE;
                    end
                    else
                    begin
                        tmr_r <= tmr_r - 1'b1;
                    end
            endcase
        end
    end

    // a sample period starts at each pop; with nothing queued the tick waits at zero,
    // so a sample arriving in play with the tick at zero plays on the next edge with force_on set, else one edge later via linger
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tick_r <= '0;
        end
        else if (state_r != HWPS_ST_PLAY)
        begin
            tick_r <= '0;
        end
        else if (pop)
        begin
            tick_r <= HWPS_CNT_W'(TICK_CYC - 1);
        end
        else if (tick_r != '0)
        begin
            tick_r <= tick_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pwr_r <= 1'b0;
        end
        else
        begin
            pwr_r <= (state_r == HWPS_ST_WAKE) || (state_r == HWPS_ST_PLAY)
                     || (state_r == HWPS_ST_LINGER);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dac_r <= '{data: HWPS_MID_SCALE, strobe: 1'b0};
        end
        else
        begin
            dac_r.strobe <= pop;
            if (pop)
            begin
                dac_r.data <= qmem[rd_ptr_r];
            end
            else if (state_r == HWPS_ST_IDLE || state_r == HWPS_ST_STANDBY)
            begin
                dac_r.data <= HWPS_MID_SCALE;
            end
        end
    end

    assign boost_en = pwr_r;
    assign amp_en   = pwr_r;
    assign dac      = dac_r;

endmodule

// [testbench/hwps_asserts.sv]
`timescale 1ns/100ps
module hwps_asserts
    import hwps_pkg::*;
#(
    parameter int unsigned WAKE_CYC = HWPS_WAKE_CYC
)(
    input wire logic        core_clk,      // clock
    input wire logic        sys_rst,       // reset
    input wire logic        s_axi_awready, // aw ready
    input wire logic        s_axi_wready,  // w ready
    input wire logic [1:0]  s_axi_bresp,   // b response
    input wire logic        s_axi_bvalid,  // b valid
    input wire logic        s_axi_bready,  // b ready
    input wire logic [31:0] s_axi_rdata,   // r data
    input wire logic        s_axi_rvalid,  // r valid
    input wire logic        s_axi_rready,  // r ready
    input wire logic        boost_en,      // boost enable
    input wire logic        amp_en,        // amp enable
    input wire hwps_dac_t   dac            // dac sample
);
    int unsigned on_cnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // saturates so a long play never wraps back into the wake window
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            on_cnt <= '0;
        else if (!boost_en || on_cnt < WAKE_CYC)
            on_cnt <= boost_en ? on_cnt + 32'h0000_0001 : '0;
    end
    a_enables_paired: assert property (boost_en == amp_en)
        else $error("boost and amp enables differ");
    a_strobe_powered: assert property (dac.strobe |-> boost_en)
        else $error("sample played with stage off");
    a_wake_first: assert property (dac.strobe |-> on_cnt >= WAKE_CYC - 2)
        else $error("sample played before wake-up done");
    a_tick_gap: assert property (dac.strobe |=> (!dac.strobe) [*7])
        else $error("samples closer than one tick");
    a_idle_mid: assert property (!boost_en |-> dac.data == HWPS_MID_SCALE)
        else $error("dac not mid-scale while idle");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    c_play: cover property (dac.strobe);
    c_wake: cover property ($rose(boost_en));
    c_refuse: cover property (s_axi_bvalid && s_axi_bresp == HWPS_RESP_SLVERR);
endmodule

bind hwps_sequencer hwps_asserts #(.WAKE_CYC(WAKE_CYC)) u_asserts (
    .core_clk, .sys_rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .boost_en, .amp_en, .dac
);

// [testbench/hwps_host_model.sv]
`timescale 1ns/100ps
module hwps_host_model (
    input  wire logic        core_clk,      // clock
    output logic [7:0]       s_axi_awaddr,  // aw address
    output logic             s_axi_awvalid, // aw valid
    input  wire logic        s_axi_awready, // aw ready
    output logic [31:0]      s_axi_wdata,   // w data
    output logic [3:0]       s_axi_wstrb,   // w strobes
    output logic             s_axi_wvalid,  // w valid
    input  wire logic        s_axi_wready,  // w ready
    input  wire logic [1:0]  s_axi_bresp,   // b response
    input  wire logic        s_axi_bvalid,  // b valid
    output logic             s_axi_bready,  // b ready
    output logic [7:0]       s_axi_araddr,  // ar address
    output logic             s_axi_arvalid, // ar valid
    input  wire logic        s_axi_arready, // ar ready
    input  wire logic [31:0] s_axi_rdata,   // r data
    input  wire logic [1:0]  s_axi_rresp,   // r response
    input  wire logic        s_axi_rvalid,  // r valid
    output logic             s_axi_rready   // r ready
);
    logic hang = 1'b0;
    int   slow = 0;
    initial
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
         s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    // released payload is inverted so a late sample cannot see the old value
    task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ta;
        logic tw;
        n = 0;
        ta = 1'b0;
        tw = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ta && tw) && n < 200)
        begin
            @(posedge core_clk);
            n++;
            ta = ta || s_axi_awready;
            tw = tw || s_axi_wready;
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
        repeat (slow) @(posedge core_clk);
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (!s_axi_bvalid && n < 400);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        hang = hang || (n >= 400);
    endtask
    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (!s_axi_arready && n < 200);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        repeat (slow) @(posedge core_clk);
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (!s_axi_rvalid && n < 400);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        hang = hang || (n >= 400);
    endtask
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb
    import hwps_pkg::*;
();
    localparam int WAKE = 20;
    localparam int TICK = 8;
    localparam int STEP = 16;
    logic        core_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, boost_en, amp_en, irq, pwr_d;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, got;
    hwps_dac_t   dac;
    int          err_total, n_compared, cyc, t_on, t_off, n;
    logic [15:0] seed = 16'h0015;
    logic [7:0]  v [3];
    logic [7:0]  s_q [$];
    int          s_t [$];
    hwps_sequencer #(.WAKE_CYC(WAKE), .TICK_CYC(TICK), .TO_STEP_CYC(STEP)) uut (
        .core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .boost_en, .amp_en, .dac, .irq);
    hwps_host_model uhost (
        .core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    function automatic int to_cyc(int sel);
        return (sel + 1) * STEP;
    endfunction
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic results();
        err_total = err_total + int'(uhost.hang);
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        logic [1:0] r;
        uhost.write(a, d, r);
        if (uhost.hang)
            results();
        chk("bresp", er, r);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        uhost.read(a, d, r);
        if (uhost.hang)
            results();
        chk("rdata", e, d & m);
        chk("rresp", er, r);
    endtask
    task automatic wait_pwr(logic lvl, int lim);
        int k;
        k = 0;
        while (boost_en !== lvl && k < lim)
        begin
            @(posedge core_clk);
            k++;
        end
        t_off = cyc;
        chk("boost_en", lvl, boost_en);
        if (boost_en !== lvl)
            results();
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // stamps taken from pre-edge values, so they do not race the design
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (dac.strobe === 1'b1)
        begin
            s_q.push_back(dac.data);
            s_t.push_back(cyc);
        end
        if (boost_en === 1'b1 && pwr_d !== 1'b1)
            t_on = cyc;
        pwr_d = boost_en;
    end
    initial
    begin
        sys_rst = 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk("boost_en", 0, boost_en);
        chk("irq", 0, irq);
        rd(HWPS_OFS_CTRL, 32'h0000_0001, 32'h0000_0001, HWPS_RESP_OKAY);
        $display("test reset done");
        for (int sel = 0; sel < 4; sel++)
        begin
            wr(HWPS_OFS_CTRL, sel << 2, HWPS_RESP_OKAY);
            rd(HWPS_OFS_STAT, 32'h0000_003C, 32'h0000_0004, HWPS_RESP_OKAY);
            s_q.delete();
            s_t.delete();
            for (int k = 0; k < 3; k++)
            begin
                seed = lfsr(seed);
                v[k] = seed[7:0];
                uhost.slow = int'(seed[9:8]);
                wr(HWPS_OFS_SAMPLE, {24'h00_0000, v[k]}, HWPS_RESP_OKAY);
            end
            wait_pwr(1'b0, 2000);
            chk("samples", 3, s_q.size());
            for (int k = 0; k < 3; k++)
                chk("dac data", v[k], s_q[k]);
            chk("wake", 1, (s_t[0] - t_on) inside {[WAKE - 2:WAKE + 2]});
            chk("tick", TICK, s_t[2] - s_t[1]);
            chk("linger", 1, (t_off - s_t[2]) inside {[to_cyc(sel):to_cyc(sel) + TICK + 4]});
        end
        $display("test auto wake done");
        uhost.slow = 0;
        wr(HWPS_OFS_CTRL, 32'h0000_0002, HWPS_RESP_OKAY);
        wait_pwr(1'b1, 4);
        repeat (WAKE + to_cyc(3)) @(posedge core_clk);
        chk("force held", 1, boost_en);
        s_q.delete();
        wr(HWPS_OFS_SAMPLE, 32'h0000_007F, HWPS_RESP_OKAY);
        repeat (TICK + 2) @(posedge core_clk);
        chk("fast play", 1, s_q.size());
        wr(HWPS_OFS_CTRL, 32'h0000_0000, HWPS_RESP_OKAY);
        wait_pwr(1'b0, to_cyc(0) + 2 * TICK + 4);
        $display("test force done");
        got = HWPS_RESP_OKAY;
        n = 0;
        while (got === HWPS_RESP_OKAY && n < 500)
        begin
            seed = lfsr(seed);
            uhost.write(HWPS_OFS_SAMPLE, {24'h00_0000, seed[7:0]}, got);
            n++;
        end
        chk("refused", HWPS_RESP_SLVERR, got);
        chk("depth", 1, n > HWPS_QDEPTH);
        chk("irq masked", 0, irq);
        rd(HWPS_OFS_STAT, 32'h0000_0001, 32'h0000_0001, HWPS_RESP_OKAY);
        wr(HWPS_OFS_IRQ_MASK, 32'h0000_0008, HWPS_RESP_OKAY);
        chk("irq", 1, irq);
        wr(HWPS_OFS_IRQ_STAT, 32'h0000_0008, HWPS_RESP_OKAY);
        chk("irq cleared", 0, irq);
        repeat (2 * TICK) @(posedge core_clk);
        wr(HWPS_OFS_SAMPLE, {24'h00_0000, seed[7:0]}, HWPS_RESP_OKAY);
        $display("test full done");
        wr(HWPS_OFS_CTRL, 32'h0000_0001, HWPS_RESP_OKAY);
        wait_pwr(1'b0, 4);
        rd(HWPS_OFS_STAT, 32'h0000_001C, 32'h0000_0000, HWPS_RESP_OKAY);
        wr(HWPS_OFS_SAMPLE, 32'h0000_0011, HWPS_RESP_SLVERR);
        rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, HWPS_RESP_SLVERR);
        $display("test standby done");
        results();
    end
endmodule
